// ===== hdl/uart_rx_status.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Overrun set when second frame completes while previous still unread.
// - On overrun new frame dropped, held data kept.
// - Overrun clears by status-one read while set, then data-low read.
// - Noise flag set with receive-full, never on overrun frames.
// - Noise clears by status-one read then data-low read.
// - Framing error set when stop bit is zero, not on overrun.
// - While framing error set, no further frames accepted.
// - Framing error clears by status-one read then data-low read.
// - Parity error when enabled and parity mismatches type; not on overrun.
// - Parity error clears by status-one read then data-low read.
// - Receiver sleep suppresses the idle-line flag.
// - Transmit invert bit flips NRZ output polarity.
// - Infrared: normal high pulse idle low, inverted low pulse idle high.
// - Receive invert bit flips incoming NRZ and infrared levels.
// - Long-break bit stretches break to 13 or 14 bits.
// - Direction bit drives transmit pin only in single-wire mode.
// - Receiver-active sets on zero in first slot, clears on idle.
// - Line option register at 0x0005, always readable; writable except receiver-active bit.
// - Receive-full set when frame moves into data register.
// - Receive irq enable lets receive-full or overrun request interrupt.
module uart_rx_status
  import uart_status_pkg::*;
#(
  parameter int DATA_W = 9
)
(
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Avalon-MM slave
  input  wire logic [3:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [3:0]       avs_byteenable_i,
  input  wire logic [31:0]      avs_writedata_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  output logic      [1:0]       avs_response_o,
  // Receive engine side
  input  wire rx_frame_t        rx_frame_i,
  input  wire logic             nine_bit_i,
  input  wire logic             first_slot_zero_i,
  input  wire logic             idle_char_i,
  input  wire logic             tdre_i,
  input  wire logic             tc_i,
  // Transmit engine side
  input  wire logic             tx_bit_i,
  input  wire logic             ir_pulse_i,
  input  wire logic             ir_tx_active_i,
  input  wire logic             rx_pin_i,
  // Line and engine outputs
  output logic                  tx_pin_o,
  output logic                  tx_pin_oe_o,
  output logic                  rx_bit_o,
  output logic      [3:0]       break_len_o,
  output logic                  rx_accept_o,
  output logic      [DATA_W-1:0] rx_data_o,
  output logic                  rx_irq_o
);

  logic [7:0]        lineopt_r;
  logic [7:0]        ctrl_r;
  logic [DATA_W-1:0] hold_r;
  logic              receive_holding_full_r, idle_r, ovr_r, noise_r, frame_r, par_r, raf_r;
  logic [3:0]        seen_r;
  logic              seen_receive_holding_full_r, seen_idle_r;
  clr_seq_t          seq_r;
  logic              ack_r;

  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] idx);
    is_addr = (a == idx);
  endfunction : is_addr

  logic stat1_rd, data_rd, lineopt_wr, ctrl_wr, new_frame, overrun_ev, par_bad;
  logic clr_ok, valid_addr;
  assign valid_addr = is_addr(avs_address_i, STAT1_IDX) | is_addr(avs_address_i, LINEOPT_IDX)
                    | is_addr(avs_address_i, DATA_LO_IDX) | is_addr(avs_address_i, CTRL_IDX);
  // One wait cycle per access; the access takes effect when ack_r is high
  assign stat1_rd   = ack_r & avs_read_i & is_addr(avs_address_i, STAT1_IDX);
  assign data_rd    = ack_r & avs_read_i & is_addr(avs_address_i, DATA_LO_IDX);
  assign lineopt_wr = ack_r & avs_write_i & avs_byteenable_i[0]
                    & is_addr(avs_address_i, LINEOPT_IDX);
  assign ctrl_wr    = ack_r & avs_write_i & avs_byteenable_i[0]
                    & is_addr(avs_address_i, CTRL_IDX);
  assign new_frame  = rx_frame_i.done & ~frame_r;
  assign overrun_ev = new_frame & receive_holding_full_r;
  assign par_bad    = ctrl_r[PCE_BIT]
                    & ((^rx_frame_i.data[DATA_W-2:0] ^ rx_frame_i.parity_bit) != ctrl_r[PODD_BIT]);
  assign clr_ok     = data_rd & (seq_r == SEQ_ARMED);

  // Bus handshake
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      avs_readdata_o <= 32'h0;
      avs_response_o <= 2'h0;
    end
    else if ((avs_read_i | avs_write_i) & ~ack_r)
    begin
      avs_response_o <= valid_addr ? 2'h0 : 2'h3;
      avs_readdata_o <= 32'h0;
      if (avs_read_i)
        case (avs_address_i)
          STAT1_IDX:    avs_readdata_o[7:0] <= {tdre_i, tc_i, receive_holding_full_r, idle_r,
                                                ovr_r, noise_r, frame_r, par_r};
          LINEOPT_IDX:  avs_readdata_o[7:0] <= {3'h0, lineopt_r[4:1], raf_r};
          DATA_LO_IDX:  avs_readdata_o[7:0] <= hold_r[7:0];
          CTRL_IDX:     avs_readdata_o[7:0] <= ctrl_r;
          default:      avs_readdata_o <= 32'h0;
        endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_r);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      lineopt_r <= LINEOPT_RST;
    else if (lineopt_wr)
      lineopt_r <= {3'h0, avs_writedata_i[4:0] & LINEOPT_WMASK};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ctrl_r <= CTRL_RST;
    else if (ctrl_wr)
      ctrl_r <= avs_writedata_i[7:0];
  end

  // capture flags seen by status read
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      seq_r       <= SEQ_IDLE;
      seen_r      <= 4'h0;
      seen_receive_holding_full_r <= 1'b0;
      seen_idle_r <= 1'b0;
    end
    else if (stat1_rd)
    begin
      seq_r       <= SEQ_ARMED;
      seen_r      <= {ovr_r, noise_r, frame_r, par_r};
      seen_receive_holding_full_r <= receive_holding_full_r;
      seen_idle_r <= idle_r;
    end
    else if (data_rd)
    begin
      seq_r       <= SEQ_IDLE;
      seen_r      <= 4'h0;
      seen_receive_holding_full_r <= 1'b0;
      seen_idle_r <= 1'b0;
    end
  end

  // receive full, hold data kept on overrun
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      receive_holding_full_r <= 1'b0;
      hold_r <= '0;
    end
    else if (new_frame & ~receive_holding_full_r)
    begin
      receive_holding_full_r <= 1'b1;
      hold_r <= rx_frame_i.data;
    end
    else if (clr_ok & seen_receive_holding_full_r)
      receive_holding_full_r <= 1'b0;
  end

  // overrun set wins; cleared only by armed data read
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ovr_r <= 1'b0;
    else if (overrun_ev)
      ovr_r <= 1'b1;
    else if (clr_ok & seen_r[3])
      ovr_r <= 1'b0;
  end

  // error flags with receive full; clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      noise_r <= 1'b0;
      frame_r <= 1'b0;
      par_r   <= 1'b0;
    end
    else
    begin
      if (new_frame & ~receive_holding_full_r & rx_frame_i.noise)
        noise_r <= 1'b1;
      else if (clr_ok & seen_r[2])
        noise_r <= 1'b0;
      if (new_frame & ~receive_holding_full_r & ~rx_frame_i.stop_bit)
        frame_r <= 1'b1;
      else if (clr_ok & seen_r[1])
        frame_r <= 1'b0;
      if (new_frame & ~receive_holding_full_r & par_bad)
        par_r <= 1'b1;
      else if (clr_ok & seen_r[0])
        par_r <= 1'b0;
    end
  end

  // idle suppressed in sleep; receiver active
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      idle_r <= 1'b0;
      raf_r  <= 1'b0;
    end
    else
    begin
      if (idle_char_i & ~ctrl_r[SLEEP_BIT])
        idle_r <= 1'b1;
      else if (clr_ok & seen_idle_r)
        idle_r <= 1'b0;
      if (first_slot_zero_i)
        raf_r <= 1'b1;
      else if (idle_char_i)
        raf_r <= 1'b0;
    end
  end

  // Pin and engine outputs all registered
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tx_pin_o    <= 1'b1;
      tx_pin_oe_o <= 1'b1;
      rx_bit_o    <= 1'b1;
      break_len_o <= BRK_SHORT_8;
      rx_accept_o <= 1'b1;
      rx_data_o   <= '0;
      rx_irq_o    <= 1'b0;
    end
    else
    begin
      // polarity of NRZ and infrared output
      if (ctrl_r[IREN_BIT])
        tx_pin_o <= (ir_tx_active_i & ir_pulse_i) ^ lineopt_r[TXINV_BIT];
      else
        tx_pin_o <= tx_bit_i ^ lineopt_r[TXINV_BIT];
      tx_pin_oe_o <= ~ctrl_r[SWM_BIT] | lineopt_r[DIR_BIT];
      // receive polarity; infrared pulse means zero
      if (ctrl_r[IREN_BIT])
        rx_bit_o <= ~(rx_pin_i ^ lineopt_r[RXINV_BIT]);
      else
        rx_bit_o <= rx_pin_i ^ lineopt_r[RXINV_BIT];
      case ({lineopt_r[BRK_BIT], nine_bit_i})
        2'b00:   break_len_o <= BRK_SHORT_8;
        2'b01:   break_len_o <= BRK_SHORT_9;
        2'b10:   break_len_o <= BRK_LONG_8;
        default: break_len_o <= BRK_LONG_9;
      endcase
      // engine stalls on framing error or stale overrun
      rx_accept_o <= ~frame_r & ~ovr_r;
      rx_data_o   <= hold_r;
      rx_irq_o    <= ctrl_r[RIE_BIT] & (receive_holding_full_r | ovr_r);
    end
  end

  // Checks
  ovr_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    overrun_ev |=> (hold_r == $past(hold_r)))
    else $error("held data changed on overrun");
  ovr_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    overrun_ev |=> ovr_r)
    else $error("overrun not set");
  ovr_clr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ($fell(ovr_r) & $past(rst_n_i)) |-> $past(clr_ok))
    else $error("overrun cleared without sequence");
  noise_ovr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (overrun_ev & ~noise_r) |=> ~noise_r)
    else $error("noise set on overrun");
  frame_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (new_frame & ~receive_holding_full_r & ~rx_frame_i.stop_bit) |=> (frame_r & receive_holding_full_r))
    else $error("framing error missing");
  frame_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_r & receive_holding_full_r & rx_frame_i.done & ~clr_ok) |=> (receive_holding_full_r & ~$changed(hold_r)))
    else $error("frame accepted under framing error");
  par_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (new_frame & ~receive_holding_full_r & par_bad) |=> par_r)
    else $error("parity error missing");
  idle_sleep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctrl_r[SLEEP_BIT] & ~idle_r & ~clr_ok) |=> ~idle_r)
    else $error("idle set in sleep");
  raf_clr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (idle_char_i & ~first_slot_zero_i) |=> ~raf_r)
    else $error("active flag not cleared");
  dir_pin_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ~ctrl_r[SWM_BIT] |=> tx_pin_oe_o)
    else $error("pin not driven outside single-wire");
  irq_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctrl_r[RIE_BIT] & ovr_r) |=> rx_irq_o)
    else $error("overrun request missing");

endmodule : uart_rx_status

// ===== hdl/uart_status_pkg.sv
package uart_status_pkg;

  // Byte addresses on the Avalon-MM word bus
  localparam logic [3:0] STAT1_ADDR    = 4'h4;
  localparam logic [3:0] LINEOPT_ADDR  = 4'h5;
  localparam logic [3:0] DATA_LO_ADDR  = 4'h7;
  localparam logic [3:0] CTRL_ADDR     = 4'h8;
  localparam logic [3:0] STAT1_IDX     = 4'h4;
  localparam logic [3:0] LINEOPT_IDX   = 4'h5;
  localparam logic [3:0] DATA_LO_IDX   = 4'h7;
  localparam logic [3:0] CTRL_IDX      = 4'h8;

  // Status one field positions
  localparam int TDRE_BIT  = 7;
  localparam int TC_BIT    = 6;
  localparam int RECEIVE_HOLDING_FULL_BIT  = 5;
  localparam int IDLE_BIT  = 4;
  localparam int OVR_BIT   = 3;
  localparam int NOISE_BIT = 2;
  localparam int FRAME_BIT = 1;
  localparam int PAR_BIT   = 0;

  // Line option field positions
  localparam int TXINV_BIT = 4;
  localparam int RXINV_BIT = 3;
  localparam int BRK_BIT   = 2;
  localparam int DIR_BIT   = 1;
  localparam int RAF_BIT   = 0;

  // Control register field positions
  localparam int PCE_BIT   = 0;
  localparam int PODD_BIT  = 1;
  localparam int SLEEP_BIT = 2;
  localparam int RIE_BIT   = 3;
  localparam int SWM_BIT   = 4;
  localparam int IREN_BIT  = 5;

  localparam logic [7:0] LINEOPT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [4:0] LINEOPT_WMASK = 5'h1E;

  // Break lengths in bit times, normal and long
  localparam logic [3:0] BRK_SHORT_8 = 4'hA;
  localparam logic [3:0] BRK_SHORT_9 = 4'hB;
  localparam logic [3:0] BRK_LONG_8  = 4'hD;
  localparam logic [3:0] BRK_LONG_9  = 4'hE;

  typedef struct packed {
    logic       done;
    logic [8:0] data;
    logic       noise;
    logic       stop_bit;
    logic       parity_bit;
  } rx_frame_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01
  } clr_seq_t;

endpackage : uart_status_pkg

// ===== sim/line_peer.sv
`timescale 1ns/1ns
module line_peer
  import uart_status_pkg::*;
(
  // Clock
  input  wire logic clk_sys_i,
  // Receive engine events
  output rx_frame_t  rx_frame_o,
  output logic       first_slot_zero_o,
  output logic       idle_char_o
);
  initial
  begin
    rx_frame_o        = '0;
    first_slot_zero_o = 1'b0;
    idle_char_o       = 1'b0;
  end

  // Fields are inverted after the pulse so stale values can never look valid
  task automatic send(input logic [8:0] d, input logic nz, sb, pb);
    @(posedge clk_sys_i);
    rx_frame_o <= {1'b1, d, nz, sb, pb};
    @(posedge clk_sys_i);
    rx_frame_o <= {1'b0, ~d, ~nz, ~sb, ~pb};
  endtask : send

  // One-cycle start-slot or idle-character event
  task automatic event_pulse(input logic slot);
    @(posedge clk_sys_i);
    first_slot_zero_o <= slot;
    idle_char_o       <= !slot;
    @(posedge clk_sys_i);
    first_slot_zero_o <= 1'b0;
    idle_char_o       <= 1'b0;
  endtask : event_pulse
endmodule : line_peer

// ===== sim/uart_rx_status_and_line_options_bench.sv
`timescale 1ns/1ns
module uart_rx_status_and_line_options_bench;
  import uart_status_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rd;
  logic        avs_waitrequest_o;
  logic [1:0]  avs_response_o, rsp;
  rx_frame_t   rx_frame_i;
  logic        nine_bit_i = 1'b0;
  logic        tx_bit_i = 1'b1;
  logic        rx_pin_i = 1'b1;
  logic        ir_pulse_i = 1'b0;
  logic        ir_tx_active_i = 1'b0;
  logic        tdre_i = 1'b1;
  logic        tc_i = 1'b0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic        first_slot_zero_i, idle_char_i;
  logic        tx_pin_o, tx_pin_oe_o, rx_bit_o, rx_accept_o, rx_irq_o;
  logic [3:0]  break_len_o;
  logic [8:0]  rx_data_o, d1;
  logic        nz, sb, pb, podd, pf;
  logic [4:0]  lo;
  integer      seed = 32'h2734;
  int          miscompares = 0;
  int          n_tests = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  uart_rx_status uart_rx_status_inst (
    .clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .avs_response_o, .rx_frame_i, .nine_bit_i, .first_slot_zero_i, .idle_char_i,
    .tdre_i, .tc_i, .tx_bit_i, .ir_pulse_i, .ir_tx_active_i,
    .rx_pin_i, .tx_pin_o, .tx_pin_oe_o, .rx_bit_o, .break_len_o, .rx_accept_o,
    .rx_data_o, .rx_irq_o
  );

  line_peer line_peer_inst (
    .clk_sys_i, .rx_frame_o(rx_frame_i), .first_slot_zero_o(first_slot_zero_i),
    .idle_char_o(idle_char_i)
  );

  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Request held until waitrequest is sampled low; no latency assumed
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    avs_read_i      <= !w;
    avs_write_i     <= w;
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    do
      @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0);
    rd  = avs_readdata_o;
    rsp = avs_response_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  function automatic logic [7:0] st(input logic f, o, n, e, p);
    return {tdre_i, tc_i, f, 1'b0, o, n, e, p};
  endfunction : st

  // Idle flag masked: its set condition lies outside this block
  task automatic stat(input logic [7:0] e);
    bus(1'b0, STAT1_ADDR, 8'h00);
    chk("status one", {24'h0, e}, rd & 32'hEF);
  endtask : stat

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    complete_run();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    bus(1'b0, LINEOPT_ADDR, 8'h00);
    chk("line option reset", {24'h0, LINEOPT_RST}, rd);
    chk("break reset", BRK_SHORT_8, break_len_o);
    bus(1'b0, 4'h3, 8'h00);
    chk("unmapped response", 2'b11, rsp);
    // Mode 1 is single-wire, mode 2 is infrared
    for (int m = 0; m < 3; m++)
    begin
      bus(1'b1, CTRL_ADDR, {2'h0, m[1], m[0], 4'h0});
      for (int i = 0; i < 16; i++)
      begin
        lo = {i[3:0], 1'b1};
        nine_bit_i <= $random(seed);
        tx_bit_i   <= $random(seed);
        rx_pin_i   <= $random(seed);
        ir_pulse_i     <= $random(seed);
        ir_tx_active_i <= $random(seed);
        bus(1'b1, LINEOPT_ADDR, {3'h0, lo});
        bus(1'b0, LINEOPT_ADDR, 8'h00);
        repeat (2) @(posedge clk_sys_i);
        chk("line option", {27'h0, lo[4:1], 1'b0}, rd);
        chk("tx pin", (m[1] ? ir_tx_active_i & ir_pulse_i : tx_bit_i) ^ lo[4],
            tx_pin_o);
        chk("rx bit", rx_pin_i ^ lo[3] ^ m[1], rx_bit_o);
        chk("break", lo[2] ? (nine_bit_i ? BRK_LONG_9 : BRK_LONG_8)
                           : (nine_bit_i ? BRK_SHORT_9 : BRK_SHORT_8), break_len_o);
        chk("pin drive", m[0] ? lo[1] : 1'b1, tx_pin_oe_o);
      end
    end
    bus(1'b1, LINEOPT_ADDR, 8'h00);
    // Only lane 0 carries the byte registers
    avs_byteenable_i <= 4'hE;
    bus(1'b1, LINEOPT_ADDR, 8'h1E);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, LINEOPT_ADDR, 8'h00);
    chk("lane gate", 32'h0, rd);
    podd = $random(seed);
    bus(1'b1, CTRL_ADDR, {4'h0, 1'b1, 1'b0, podd, 1'b1});
    for (int k = 0; k < 8; k++)
    begin
      {tdre_i, tc_i} <= $random(seed);
      d1 = $random(seed);
      {nz, sb, pb} = $random(seed);
      pf = (^d1[7:0] ^ pb) != podd;
      line_peer_inst.send(d1, nz, sb, pb);
      // A frame behind a framing error must neither land nor overrun
      if (!sb)
        line_peer_inst.send(~d1, 1'b1, 1'b1, 1'b0);
      repeat (2) @(posedge clk_sys_i);
      chk("accept", sb, rx_accept_o);
      chk("data out", d1, rx_data_o);
      chk("irq", 1'b1, rx_irq_o);
      if (k[0])
      begin
        // Data read after a status read that saw no flags set must clear nothing
        bus(1'b0, DATA_LO_ADDR, 8'h00);
        stat(st(1'b1, 1'b0, nz, ~sb, pf));
      end
      stat(st(1'b1, 1'b0, nz, ~sb, pf));
      bus(1'b0, DATA_LO_ADDR, 8'h00);
      chk("data low", d1[7:0], rd);
      stat(st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      chk("irq clear", 1'b0, rx_irq_o);
    end
    d1 = $random(seed);
    line_peer_inst.send(d1, 1'b0, 1'b1, ^d1[7:0] ^ podd);
    stat(st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    line_peer_inst.send(~d1, 1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    chk("accept overrun", 1'b0, rx_accept_o);
    chk("data out kept", d1, rx_data_o);
    bus(1'b0, DATA_LO_ADDR, 8'h00);
    chk("data kept", d1[7:0], rd);
    stat(st(1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
    bus(1'b0, DATA_LO_ADDR, 8'h00);
    stat(st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    d1 = $random(seed);
    line_peer_inst.send(d1, 1'b0, 1'b1, ^d1[7:0] ^ podd);
    stat(st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    bus(1'b0, DATA_LO_ADDR, 8'h00);
    chk("data after overrun", d1[7:0], rd);
    bus(1'b1, CTRL_ADDR, 8'h04);
    line_peer_inst.event_pulse(1'b1);
    bus(1'b0, LINEOPT_ADDR, 8'h00);
    chk("active set", 1'b1, rd[RAF_BIT]);
    line_peer_inst.event_pulse(1'b0);
    bus(1'b0, LINEOPT_ADDR, 8'h00);
    chk("active clear", 1'b0, rd[RAF_BIT]);
    bus(1'b0, STAT1_ADDR, 8'h00);
    chk("idle asleep", 1'b0, rd[IDLE_BIT]);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk("wait reset", 1'b1, avs_waitrequest_o);
    chk("accept reset", 1'b1, rx_accept_o);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk("control reset", {24'h0, CTRL_RST}, rd);
    // Sleep was cleared by reset, so idle must now be flagged
    line_peer_inst.event_pulse(1'b0);
    bus(1'b0, STAT1_ADDR, 8'h00);
    chk("idle awake", 1'b1, rd[IDLE_BIT]);
    complete_run();
  end
endmodule : uart_rx_status_and_line_options_bench
